// ---- logic/charger_timer_regs.vh ----
`ifndef CHARGER_TIMER_REGS_VH
`define CHARGER_TIMER_REGS_VH
// Charge state codes, one-hot
`define ST_IDLE 7'h01
`define ST_PRECOND 7'h02
`define ST_FAST 7'h04
`define ST_TOPOFF 7'h08
`define ST_EOC 7'h10
`define ST_TEMP_FAULT 7'h20
`define ST_TIMEOUT_FAULT 7'h40
// Timeout select codes
`define SEL_DISABLED 2'h3
// Times in minutes
`define PRE_T0_MIN 40
`define PRE_T1_MIN 60
`define PRE_T2_MIN 80
`define TOT_T0_MIN 180
`define TOT_T1_MIN 240
`define TOT_T2_MIN 300
// Clock rate and minute tick
`define CLK_HZ 20000000
`define MINUTE_CYCLES (`CLK_HZ * 60)
`endif

// ---- logic/charger_timer_status.v ----
// Overview of operation
// - Reading timer event flag returns pending state and clears it.
// - Precondition select 00/01/10 gives 40/60/80 minutes; 11 disables.
// - Total select 00/01/10 gives 3/4/5 hours; 11 disables.
// - Charge indicator sinks only in precondition, fast-charge, top-off states.
// - Charging suspends while either temperature comparator trips.
// - Temperature leaving valid range raises interrupt when both enables set.
// - Temperature returning to valid range raises interrupt when both enables set.
// - Temperature level bit is 1 inside valid range, else 0.
// - Reading temperature event flag returns pending state and clears it.
// - Supply below battery reconfigures power switch for minimal battery drain.
// - Precondition timer expiry raises interrupt when both enables set.
// - Total timer expiry raises interrupt when both enables set.
// - Timer expired level is 1 after either timeout, else 0.
// - Precondition timeout before threshold enters timeout-fault state.
`include "charger_timer_regs.vh"
`default_nettype none
module charger_timer_status #(
    parameter MINUTE_CYCLES = `MINUTE_CYCLES
) (
    input wire clk, // 20 MHz clock
    input wire rst_n, // Async reset, active low
    input wire [6:0] charge_state, // One-hot charger state
    input wire new_cycle, // Pulse at start of a charge cycle
    input wire [1:0] precharge_timeout_sel, // Precondition timeout select
    input wire [1:0] total_timeout_sel, // Total timeout select
    input wire hot_limit_trip, // Comparator: sense below hot limit voltage
    input wire cold_limit_trip, // Comparator: sense above cold limit voltage
    input wire supply_below_battery, // Comparator: supply input under battery
    input wire temp_exit_irq_en, // Interrupt on leaving valid range
    input wire temp_return_irq_en, // Interrupt on returning to valid range
    input wire precharge_expiry_irq_en, // Interrupt on precondition expiry
    input wire overall_expiry_irq_en, // Interrupt on total expiry
    input wire timer_flag_en, // Timer event flag enable
    input wire heat_flag_en, // Temperature event flag enable
    input wire timer_flag_read, // Read strobe of timer event flag
    input wire heat_flag_read, // Read strobe of temperature event flag
    output reg timer_event_flag, // Pending timer event
    output reg pack_heat_event_flag, // Pending temperature event
    output reg timer_expired_level, // A timeout has occurred
    output reg pack_heat_ok_level, // Temperature inside valid range
    output reg charge_suspend, // Request charger to suspend
    output reg precharge_timeout, // Pulse: precondition timeout, go to fault
    output reg total_timeout, // Pulse: total timeout
    output reg switch_reverse_block, // Power switch in reverse-block mode
    output reg charge_indicator_n_out, // Indicator pin drive value
    output reg charge_indicator_n_oe // Indicator pin enable, low while sinking
);
    reg hot_s1, hot_s2, cold_s1, cold_s2, rev_s1, rev_s2;
    reg [31:0] minute_div;
    reg [8:0] pre_min, tot_min;
    reg pre_done, tot_done;
    reg next_timer_flag, next_heat_flag;
    wire minute_tick = (minute_div == MINUTE_CYCLES - 1);
    wire in_pre = (charge_state == `ST_PRECOND);
    wire active = (charge_state == `ST_PRECOND) || (charge_state == `ST_FAST) || (charge_state == `ST_TOPOFF);
    wire temp_ok = ~hot_s2 & ~cold_s2;
    wire pre_fire;
    wire tot_fire;
    wire timer_set;
    wire heat_set;

    function [8:0] limit_min;
        input [1:0] sel;
        input total;
        begin
            case (sel)
                2'h0: limit_min = total ? 9'd`TOT_T0_MIN : 9'd`PRE_T0_MIN;
                2'h1: limit_min = total ? 9'd`TOT_T1_MIN : 9'd`PRE_T1_MIN;
                default: limit_min = total ? 9'd`TOT_T2_MIN : 9'd`PRE_T2_MIN;
            endcase
        end
    endfunction

    assign pre_fire = !pre_done && in_pre && precharge_timeout_sel != `SEL_DISABLED && minute_tick
        && (pre_min + 9'h001 == limit_min(precharge_timeout_sel, 1'b0));
    assign tot_fire = !tot_done && active && total_timeout_sel != `SEL_DISABLED && minute_tick
        && (tot_min + 9'h001 == limit_min(total_timeout_sel, 1'b1));
    assign timer_set = timer_flag_en && ((pre_fire && precharge_expiry_irq_en) || (tot_fire && overall_expiry_irq_en));
    assign heat_set = heat_flag_en && ((pack_heat_ok_level && !temp_ok && temp_exit_irq_en)
        || (!pack_heat_ok_level && temp_ok && temp_return_irq_en));

    // Comparator synchronisers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hot_s1 <= 1'b0;
            hot_s2 <= 1'b0;
            cold_s1 <= 1'b0;
            cold_s2 <= 1'b0;
            rev_s1 <= 1'b0;
            rev_s2 <= 1'b0;
        end
        else
        begin
            hot_s1 <= hot_limit_trip;
            hot_s2 <= hot_s1;
            cold_s1 <= cold_limit_trip;
            cold_s2 <= cold_s1;
            rev_s1 <= supply_below_battery;
            rev_s2 <= rev_s1;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            minute_div <= 32'h0;
            pre_min <= 9'h0;
            tot_min <= 9'h0;
            pre_done <= 1'b0;
            tot_done <= 1'b0;
        end
        else if (new_cycle)
        begin
            minute_div <= 32'h0;
            pre_min <= 9'h0;
            tot_min <= 9'h0;
            pre_done <= 1'b0;
            tot_done <= 1'b0;
        end
        else
        begin
            minute_div <= minute_tick ? 32'h0 : minute_div + 32'h1;
            if (minute_tick && in_pre && !pre_done)
                pre_min <= pre_min + 9'h001;
            if (minute_tick && active && !tot_done)
                tot_min <= tot_min + 9'h001;
            if (pre_fire)
                pre_done <= 1'b1;
            if (tot_fire)
                tot_done <= 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            precharge_timeout <= 1'b0;
            total_timeout <= 1'b0;
            timer_expired_level <= 1'b0;
        end
        else
        begin
            precharge_timeout <= pre_fire && !new_cycle;
            total_timeout <= tot_fire && !new_cycle;
            if (new_cycle)
                timer_expired_level <= 1'b0;
            else if (pre_fire || tot_fire)
                timer_expired_level <= 1'b1;
        end
    end

    // Flag next values, set wins over read
    always @*
    begin
        next_timer_flag = timer_event_flag;
        if (timer_set && !new_cycle)
            next_timer_flag = 1'b1;
        else if (timer_flag_read)
            next_timer_flag = 1'b0;
        next_heat_flag = pack_heat_event_flag;
        if (heat_set)
            next_heat_flag = 1'b1;
        else if (heat_flag_read)
            next_heat_flag = 1'b0;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_event_flag <= 1'b0;
            pack_heat_event_flag <= 1'b0;
        end
        else
        begin
            timer_event_flag <= next_timer_flag;
            pack_heat_event_flag <= next_heat_flag;
        end
    end

    // Level status and pin drive
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pack_heat_ok_level <= 1'b1;
            charge_suspend <= 1'b0;
            switch_reverse_block <= 1'b0;
            charge_indicator_n_out <= 1'b0;
            charge_indicator_n_oe <= 1'b1;
        end
        else
        begin
            pack_heat_ok_level <= temp_ok;
            charge_suspend <= ~temp_ok;
            switch_reverse_block <= rev_s2;
            // Open drain, drive value fixed low
            charge_indicator_n_out <= 1'b0;
            charge_indicator_n_oe <= ~active;
        end
    end
endmodule
`default_nettype wire

// ---- dv/charger_timer_status_checker.sv ----
`default_nettype none
module charger_timer_status_checker (
    input wire logic clk, rst_n, new_cycle, hot_limit_trip, cold_limit_trip, timer_flag_read, heat_flag_read,
    input wire logic timer_flag_en, heat_flag_en, timer_event_flag, pack_heat_event_flag, timer_expired_level,
    input wire logic pack_heat_ok_level, charge_suspend, precharge_timeout, charge_indicator_n_out,
    input wire logic charge_indicator_n_oe,
    input wire logic [6:0] charge_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_out;
        (hot_limit_trip || cold_limit_trip) [*4];
    endsequence
    a_temp_out: assert property (s_out |-> !pack_heat_ok_level)
        else $error("ok level high while out of range");
    a_suspend_tied: assert property (charge_suspend == !pack_heat_ok_level)
        else $error("suspend disagrees with ok level");
    a_sink_states: assert property (charge_indicator_n_oe == !(|($past(charge_state) & 7'h0e)))
        else $error("indicator enable wrong for state");
    a_pin_low: assert property (charge_indicator_n_out == 1'b0)
        else $error("indicator drive value not low");
    a_timer_hold: assert property (timer_event_flag && !timer_flag_read |=> timer_event_flag)
        else $error("timer flag lost without read");
    a_timer_clear: assert property (timer_flag_read && !timer_flag_en |=> !timer_event_flag)
        else $error("timer flag not cleared by read");
    a_heat_hold: assert property (pack_heat_event_flag && !heat_flag_read |=> pack_heat_event_flag)
        else $error("heat flag lost without read");
    a_heat_clear: assert property (heat_flag_read && !heat_flag_en |=> !pack_heat_event_flag)
        else $error("heat flag not cleared by read");
    a_pre_pulse: assert property (precharge_timeout |=> !precharge_timeout && timer_expired_level)
        else $error("timeout pulse too long or level missing");
    a_expired_hold: assert property (timer_expired_level && !new_cycle |=> timer_expired_level)
        else $error("expired level dropped early");
endmodule
bind charger_timer_status charger_timer_status_checker chk_u (.*);
`default_nettype wire

// ---- dv/charger_timer_status_tb.sv ----
`default_nettype none
module charger_timer_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, new_cycle = 0, hot_limit_trip = 0, cold_limit_trip = 0, supply_below_battery = 0;
    logic temp_exit_irq_en = 1, temp_return_irq_en = 1, precharge_expiry_irq_en = 1, overall_expiry_irq_en = 1;
    logic timer_flag_en = 1, heat_flag_en = 1, timer_flag_read = 0, heat_flag_read = 0;
    logic [6:0] charge_state = 7'h01;
    logic [1:0] precharge_timeout_sel = 2'h3, total_timeout_sel = 2'h3;
    logic timer_event_flag, pack_heat_event_flag, timer_expired_level, pack_heat_ok_level, charge_suspend;
    logic precharge_timeout, total_timeout, switch_reverse_block, charge_indicator_n_out, charge_indicator_n_oe;
    typedef struct {string nm; int s; logic [15:0] e;} note_t;
    note_t q[$];
    int errors = 0, checks_done = 0, n, k;
    logic [15:0] meas;
    wire [7:0] obs = {switch_reverse_block, timer_expired_level, timer_event_flag, pack_heat_event_flag,
        charge_suspend, pack_heat_ok_level, charge_indicator_n_oe, charge_indicator_n_out};
    charger_timer_status #(.MINUTE_CYCLES(4)) dut_u (.*);
    initial forever #25 clk = ~clk;
    task automatic cyc(int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic note(string nm, int s, logic [15:0] e);
        q.push_back('{nm, s, e});
    endtask
    task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(negedge clk)
        while (q.size() > 0)
        begin
            cmp(q[0].nm, q[0].e, q[0].s == 8 ? meas : 16'(obs[q[0].s]));
            q.delete(0);
        end
    // Timer run from a fresh cycle, minutes seen
    task automatic measure(logic [6:0] st);
        charge_state <= st;
        new_cycle <= 1;
        cyc(1);
        new_cycle <= 0;
        note("expired", 6, 0);
        for (k = 0; k < 1300 && !(precharge_timeout || total_timeout); k++)
            @(negedge clk);
        meas = 16'(k / 4);
        cyc(2);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #(5000 * 50);
        errors++;
        tally_and_finish;
    end
    initial
    begin
        void'($urandom(32'h421e));
        cyc(10);
        rst_n <= 1;
        note("ok", 2, 1);
        for (n = 0; n < 7; n++)
        begin
            charge_state <= 7'h01 << n;
            cyc(2);
            note("oe", 1, (n inside {1, 2, 3}) ? 0 : 1);
            note("pin", 0, 0);
        end
        hot_limit_trip <= 1;
        supply_below_battery <= 1;
        cyc(4);
        note("ok", 2, 0);
        note("suspend", 3, 1);
        note("flag", 4, 1);
        note("reverse", 7, 1);
        heat_flag_read <= 1;
        heat_flag_en <= 0;
        cold_limit_trip <= 1;
        cyc(1);
        heat_flag_read <= 0;
        heat_flag_en <= 1;
        hot_limit_trip <= 0;
        cyc(5);
        note("flag", 4, 0);
        cold_limit_trip <= 0;
        supply_below_battery <= 0;
        cyc(5);
        note("flag", 4, 1);
        note("reverse", 7, 0);
        // Range edges with their interrupt enables low are dropped
        heat_flag_read <= 1;
        temp_exit_irq_en <= 0;
        hot_limit_trip <= 1;
        cyc(1);
        heat_flag_read <= 0;
        cyc(5);
        note("flag", 4, 0);
        note("ok", 2, 0);
        temp_return_irq_en <= 0;
        hot_limit_trip <= 0;
        cyc(5);
        note("flag", 4, 0);
        note("ok", 2, 1);
        temp_exit_irq_en <= 1;
        temp_return_irq_en <= 1;
        n = $urandom % 3;
        precharge_timeout_sel <= n[1:0];
        measure(7'h02);
        note("pre min", 8, 16'(40 + 20 * n));
        note("tflag", 5, 1);
        note("expired", 6, 1);
        timer_flag_read <= 1;
        timer_flag_en <= 0;
        cyc(1);
        timer_flag_read <= 0;
        timer_flag_en <= 1;
        n = $urandom % 3;
        total_timeout_sel <= n[1:0];
        measure(7'h04);
        note("tot min", 8, 16'(180 + 60 * n));
        note("tflag", 5, 1);
        total_timeout_sel <= 2'h3;
        precharge_timeout_sel <= 2'h3;
        measure(7'h02);
        note("off min", 8, 16'd325);
        cyc(2);
        tally_and_finish;
    end
endmodule
`default_nettype wire
